// ---- rtl/pie_cfg.svh ----
// Constants for the PWM interrupt-enable block
`ifndef PIE_CFG_SVH
`define PIE_CFG_SVH
`define PIE_ADDR_W        12
`define PIE_OFS_ENABLE    12'h300
`define PIE_OFS_SET       12'h304
`define PIE_OFS_CLEAR     12'h308
`define PIE_OFS_EVENTS    12'h30c
`define PIE_BIT_HALT      1
`define PIE_BIT_SEQBEG0   2
`define PIE_BIT_SEQBEG1   3
`define PIE_BIT_SEQFIN0   4
`define PIE_BIT_SEQFIN1   5
`define PIE_BIT_PERIOD    6
`define PIE_BIT_LOOPS     7
`define PIE_EN_LSB        1
`define PIE_EN_MSB        7
`define PIE_NUM_SRC       7
`define PIE_EN_RESET      7'h00
`define PIE_DATA_ZERO     32'h0000_0000
`endif

// ---- rtl/pie_pkg.sv ----
// Types for the PWM interrupt-enable block
package pie_pkg;
    typedef logic [6:0] pie_vec_t;
    typedef enum logic [1:0] {
        PIE_OP_NONE,
        PIE_OP_WRITE,
        PIE_OP_SET,
        PIE_OP_CLEAR
    } pie_op_e;
endpackage : pie_pkg

// ---- rtl/pie_event_flag.sv ----
// One sticky event flag with set-over-clear priority
`include "pie_cfg.svh"
module pie_event_flag (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Event and clear
    input  wire logic eventPulse,
    input  wire logic clearFlag,
    // Flag state
    output logic      flag
);
    typedef struct packed {
        logic flag;
    } pie_flag_s;

    pie_flag_s state;
    pie_flag_s next_state;

    // Set wins over a clear in the same cycle
    always_comb begin
        next_state = state;
        if (clearFlag) begin
            next_state.flag = 1'b0;
        end
        if (eventPulse) begin
            next_state.flag = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flag = state.flag;

    a_flag_sets : assert property (@(posedge clk_sys) disable iff (!rst_n)
        eventPulse |=> flag)
        else $error("Event did not set its flag");
endmodule : pie_event_flag

// ---- rtl/pie_irq_enable.sv ----
// PWM interrupt-enable registers, event flags and interrupt request
//
// Overview of operation
// - Enable register at 0x300, halt bit gates
// - Two sequence-begun enable fields, one each
// - Two sequence-finished enable fields, one each
// - Period-finished enable field
// - Loop-count-reached enable field
// - Set register 0x304 sets halt; reads state
// - Set register sets sequence-begun enables; reads state
// - Set register sets sequence-finished enables; reads state
// - Set register sets period enable; reads state
// - Set register sets loop enable; reads state
// - Clear register 0x308 clears enables; reads state
// - Halt-done event raised after stop completes
// - Period-finished event raised every period end
`include "pie_cfg.svh"
module pie_irq_enable #(
    parameter int ADDR_W = `PIE_ADDR_W,
    parameter int NUM_SRC = `PIE_NUM_SRC
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [31:0]       regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic [31:0]            regRdData,
    // Event pulses from the waveform engine
    input  wire logic              haltDoneEvent,
    input  wire logic [1:0]        sequenceBegunEvent,
    input  wire logic [1:0]        sequenceFinishedEvent,
    input  wire logic              periodFinishedEvent,
    input  wire logic              loopCountReachedEvent,
    // Interrupt request
    output logic                   irqRequest
);

    // ---------------------------------------------------------------
    // Parameter checks
    // ---------------------------------------------------------------
    if (NUM_SRC != `PIE_NUM_SRC) begin : g_bad_src
        $error("Source count must match the enable bit layout");
    end
    if (ADDR_W < `PIE_ADDR_W) begin : g_bad_addr
        $error("Address width too narrow for register offsets");
    end

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        pie_pkg::pie_vec_t enable;
        logic [31:0]       rdData;
        logic              irq;
    } pie_state_s;

    pie_state_s        state;
    pie_state_s        next_state;
    pie_pkg::pie_vec_t eventVec;
    pie_pkg::pie_vec_t flagVec;
    pie_pkg::pie_vec_t flagClear;
    pie_pkg::pie_op_e  writeOp;
    logic [11:0]       offset;
    logic [31:0]       enWord;
    logic [31:0]       flagWord;
    pie_pkg::pie_vec_t wrField;

    // Only the low twelve address bits take part in the decode
    assign offset = regAddr[11:0];

    // Event inputs packed at enable-bit order (bit 0 = halt-done)
    assign eventVec = {loopCountReachedEvent,
                       periodFinishedEvent,
                       sequenceFinishedEvent,
                       sequenceBegunEvent,
                       haltDoneEvent};

    assign wrField = regWrData[`PIE_EN_MSB:`PIE_EN_LSB];

    // Word views of enables and flags, bit 0 and upper bits read zero
    always_comb begin
        enWord = `PIE_DATA_ZERO;
        enWord[`PIE_EN_MSB:`PIE_EN_LSB] = state.enable;
        flagWord = `PIE_DATA_ZERO;
        flagWord[`PIE_EN_MSB:`PIE_EN_LSB] = flagVec;
    end

    // ---------------------------------------------------------------
    // Event flags
    // ---------------------------------------------------------------
    // Writing one to a flag bit at the event offset clears it
    always_comb begin
        flagClear = '0;
        if (regWrite && offset == `PIE_OFS_EVENTS) begin
            flagClear = wrField;
        end
    end

    for (genvar i = 0; i < NUM_SRC; i++) begin : g_flag
        pie_event_flag u_flag (
            .clk_sys    (clk_sys),
            .rst_n      (rst_n),
            .eventPulse (eventVec[i]),
            .clearFlag  (flagClear[i]),
            .flag       (flagVec[i])
        );
    end

    // ---------------------------------------------------------------
    // Write decode
    // ---------------------------------------------------------------
    always_comb begin
        writeOp = pie_pkg::PIE_OP_NONE;
        if (regWrite) begin
            case (offset)
                `PIE_OFS_ENABLE: writeOp = pie_pkg::PIE_OP_WRITE;
                `PIE_OFS_SET:    writeOp = pie_pkg::PIE_OP_SET;
                `PIE_OFS_CLEAR:  writeOp = pie_pkg::PIE_OP_CLEAR;
                default:         writeOp = pie_pkg::PIE_OP_NONE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        // Shared enable state for all three register views
        case (writeOp)
            pie_pkg::PIE_OP_WRITE: begin
                next_state.enable = wrField;
            end
            pie_pkg::PIE_OP_SET: begin
                next_state.enable = state.enable | wrField;
            end
            pie_pkg::PIE_OP_CLEAR: begin
                next_state.enable = state.enable & ~wrField;
            end
            default: begin
                next_state.enable = state.enable;
            end
        endcase
        // Read data only in the cycle after a read strobe
        next_state.rdData = `PIE_DATA_ZERO;
        if (regRead) begin
            case (offset)
                `PIE_OFS_ENABLE: next_state.rdData = enWord;
                `PIE_OFS_SET:    next_state.rdData = enWord;
                `PIE_OFS_CLEAR:  next_state.rdData = enWord;
                `PIE_OFS_EVENTS: next_state.rdData = flagWord;
                default:         next_state.rdData = `PIE_DATA_ZERO;
            endcase
        end
        // Request follows enabled flags
        next_state.irq = |(flagVec & state.enable);
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state.enable <= `PIE_EN_RESET;
            state.rdData <= `PIE_DATA_ZERO;
            state.irq    <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Both outputs come straight from the state register
    assign regRdData  = state.rdData;
    assign irqRequest = state.irq;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_enable_write : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWrite && offset == `PIE_OFS_ENABLE) |=>
            state.enable == $past(regWrData[`PIE_EN_MSB:`PIE_EN_LSB]))
        else $error("Enable write not stored");

    a_halt_enable : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (flagVec[0] && !state.enable[0] && !(|(flagVec[6:1] & state.enable[6:1])))
            |=> !irqRequest)
        else $error("Disabled halt flag raised request");

    a_seq_begun : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWrite && offset == `PIE_OFS_ENABLE && regWrData[`PIE_BIT_SEQBEG1]
            && sequenceBegunEvent[1]) |=> ##1 irqRequest)
        else $error("Sequence begun interrupt missing");

    a_seq_finished : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state.enable[3] && sequenceFinishedEvent[0]) ##1 state.enable[3]
            |=> irqRequest)
        else $error("Sequence finished interrupt missing");

    a_period_end : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state.enable[5] && periodFinishedEvent) ##1 state.enable[5] |=> irqRequest)
        else $error("Period end interrupt missing");

    a_loop_count : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state.enable[6] && loopCountReachedEvent) ##1 state.enable[6] |=> irqRequest)
        else $error("Loop count interrupt missing");

    a_set_or : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWrite && offset == `PIE_OFS_SET) |=>
            state.enable == ($past(state.enable) | $past(wrField)))
        else $error("Set register did not OR in bits");

    a_set_readback : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regRead && offset == `PIE_OFS_SET && !regWrite) |=>
            regRdData[`PIE_EN_MSB:`PIE_EN_LSB] == $past(state.enable)
            && regRdData[0] == 1'b0)
        else $error("Set register read wrong");

    a_clear_andn : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWrite && offset == `PIE_OFS_CLEAR) |=>
            state.enable == ($past(state.enable) & ~$past(wrField)))
        else $error("Clear register did not clear bits");

    a_read_one_cycle : assert property (@(posedge clk_sys) disable iff (!rst_n)
        !regRead |=> regRdData == `PIE_DATA_ZERO)
        else $error("Read data outside its cycle");

    a_irq_follow : assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 irqRequest == $past(|(flagVec & state.enable)))
        else $error("Request does not follow enabled flags");

    // ---------------------------------------------------------------
    // Per-source request and flag checks
    // ---------------------------------------------------------------
    // Enabled halt-done event reaches the request two cycles later
    a_halt_irq : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state.enable[0] && haltDoneEvent) ##1 state.enable[0] |=> irqRequest)
        else $error("Halt done interrupt missing");

    // Sequence 0 begun event with its enable held
    a_seq_begun0 : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state.enable[1] && sequenceBegunEvent[0]) ##1 state.enable[1]
            |=> irqRequest)
        else $error("Sequence 0 begun interrupt missing");

    // Sequence 1 finished event with its enable held
    a_seq_finished1 : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state.enable[4] && sequenceFinishedEvent[1]) ##1 state.enable[4]
            |=> irqRequest)
        else $error("Sequence 1 finished interrupt missing");

    // Halt-done pulse leaves its flag set
    a_halt_flag : assert property (@(posedge clk_sys) disable iff (!rst_n)
        haltDoneEvent |=> flagVec[0])
        else $error("Halt done flag not set");

    // Sequence 1 begun pulse leaves its flag set
    a_seq_flag : assert property (@(posedge clk_sys) disable iff (!rst_n)
        sequenceBegunEvent[1] |=> flagVec[2])
        else $error("Sequence begun flag not set");

    // Sequence 0 finished pulse leaves its flag set
    a_seqfin_flag : assert property (@(posedge clk_sys) disable iff (!rst_n)
        sequenceFinishedEvent[0] |=> flagVec[3])
        else $error("Sequence finished flag not set");

    // Period pulse leaves its flag set
    a_period_flag : assert property (@(posedge clk_sys) disable iff (!rst_n)
        periodFinishedEvent |=> flagVec[5])
        else $error("Period finished flag not set");

    // Loop count pulse leaves its flag set
    a_loop_flag : assert property (@(posedge clk_sys) disable iff (!rst_n)
        loopCountReachedEvent |=> flagVec[6])
        else $error("Loop count flag not set");

    // No enabled flag means no request in the next cycle
    a_irq_quiet : assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(|(flagVec & state.enable)) |=> !irqRequest)
        else $error("Request without an enabled flag");

    // ---------------------------------------------------------------
    // Register view checks
    // ---------------------------------------------------------------
    // Zero written to the set register changes nothing
    a_set_zero_keep : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWrite && offset == `PIE_OFS_SET && wrField == '0) |=>
            $stable(state.enable))
        else $error("Zero set write changed enables");

    // Zero written to the clear register changes nothing
    a_clear_zero_keep : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWrite && offset == `PIE_OFS_CLEAR && wrField == '0) |=>
            $stable(state.enable))
        else $error("Zero clear write changed enables");

    // Writes to unmapped places leave the enables alone
    a_unmapped_keep : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWrite && offset != `PIE_OFS_ENABLE && offset != `PIE_OFS_SET
            && offset != `PIE_OFS_CLEAR) |=> $stable(state.enable))
        else $error("Unmapped write changed enables");

    // Enable register reads back the shared state
    a_enable_readback : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regRead && offset == `PIE_OFS_ENABLE) |=>
            regRdData[`PIE_EN_MSB:`PIE_EN_LSB] == $past(state.enable))
        else $error("Enable register read wrong");

    // Clear register reads back the shared state
    a_clear_readback : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regRead && offset == `PIE_OFS_CLEAR) |=>
            regRdData[`PIE_EN_MSB:`PIE_EN_LSB] == $past(state.enable))
        else $error("Clear register read wrong");

    // Flag view reads back the sticky flags
    a_flag_readback : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regRead && offset == `PIE_OFS_EVENTS) |=>
            regRdData[`PIE_EN_MSB:`PIE_EN_LSB] == $past(flagVec))
        else $error("Flag view read wrong");

    // A flag clear with no event pending empties the written flags
    a_flag_clear : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWrite && offset == `PIE_OFS_EVENTS && !(|eventVec)) |=>
            (flagVec & $past(wrField)) == '0)
        else $error("Flag clear did not take");

    // Bit 0 and the upper bits always read zero
    a_reserved_zero : assert property (@(posedge clk_sys) disable iff (!rst_n)
        regRdData[0] == 1'b0 && regRdData[31:`PIE_EN_MSB+1] == '0)
        else $error("Reserved read bits not zero");

    // ---------------------------------------------------------------
    // Main scenarios
    // ---------------------------------------------------------------
    c_masked_event : cover property (@(posedge clk_sys) disable iff (!rst_n)
        (flagVec != '0) && !(|(flagVec & state.enable)));

    c_set_write : cover property (@(posedge clk_sys) disable iff (!rst_n)
        regWrite && offset == `PIE_OFS_SET);
    c_clear_write : cover property (@(posedge clk_sys) disable iff (!rst_n)
        regWrite && offset == `PIE_OFS_CLEAR);
    c_irq_rise : cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(irqRequest));
    c_irq_fall : cover property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(irqRequest));
endmodule : pie_irq_enable

// ---- verification/pie_irq_enable_tb.sv ----
// Self-checking testbench for the PWM interrupt-enable block
`include "pie_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk_sys;
    logic        rst_n;
    logic [11:0] regAddr;
    logic [31:0] regWrData;
    logic        regWrite;
    logic        regRead;
    logic [31:0] regRdData;
    logic [7:0]  ev;
    logic        irqRequest;
    int          fails;
    int          n_compared;

    // Device under test, event vector uses enable bit positions
    pie_irq_enable dut (
        .clk_sys               (clk_sys),
        .rst_n                 (rst_n),
        .regAddr               (regAddr),
        .regWrData             (regWrData),
        .regWrite              (regWrite),
        .regRead               (regRead),
        .regRdData             (regRdData),
        .haltDoneEvent         (ev[1]),
        .sequenceBegunEvent    (ev[3:2]),
        .sequenceFinishedEvent (ev[5:4]),
        .periodFinishedEvent   (ev[6]),
        .loopCountReachedEvent (ev[7]),
        .irqRequest            (irqRequest)
    );

    // Clock generator, 20 ns period
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'h1;
        @(posedge clk_sys);
        regWrite  <= 1'h0;
    endtask : wr

    // One-cycle read strobe, data judged in the following cycle only
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge clk_sys);
        regRead <= 1'h0;
        #1;
        chk(regRdData, e, "read data");
    endtask : rd

    // One-cycle event pulse
    task automatic pulse(input logic [7:0] v);
        @(posedge clk_sys);
        ev <= v;
        @(posedge clk_sys);
        ev <= 8'h00;
    endtask : pulse

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Direct enable register replaces state, reserved bits read zero
    task automatic t_enable();
        wr(`PIE_OFS_ENABLE, 32'hffff_ffff);
        rd(`PIE_OFS_ENABLE, 32'h0000_00fe);
        wr(`PIE_OFS_ENABLE, 32'h0000_0054);
        rd(`PIE_OFS_ENABLE, 32'h0000_0054);
        wr(`PIE_OFS_ENABLE, 32'h0000_00aa);
        rd(`PIE_OFS_SET, 32'h0000_00aa);
    endtask : t_enable

    // Set register turns on one field at a time, zeros change nothing
    task automatic t_set();
        logic [31:0] exp;
        exp = 32'h0;
        wr(`PIE_OFS_ENABLE, 32'h0);
        for (int b = 1; b <= 7; b++) begin
            wr(`PIE_OFS_SET, 32'h1 << b);
            exp = exp | (32'h1 << b);
            rd(`PIE_OFS_SET, exp);
        end
        wr(`PIE_OFS_SET, 32'h0);
        rd(`PIE_OFS_ENABLE, 32'h0000_00fe);
    endtask : t_set

    // Clear register turns off one field at a time
    task automatic t_clear();
        logic [31:0] exp;
        exp = 32'h0000_00fe;
        wr(`PIE_OFS_CLEAR, 32'h0);
        rd(`PIE_OFS_CLEAR, exp);
        for (int b = 1; b <= 7; b++) begin
            wr(`PIE_OFS_CLEAR, 32'h1 << b);
            exp = exp & ~(32'h1 << b);
            rd(`PIE_OFS_CLEAR, exp);
        end
    endtask : t_clear

    // Unmapped place ignores writes and reads zero
    task automatic t_unmapped();
        wr(`PIE_OFS_ENABLE, 32'h0000_0002);
        wr(12'h3f0, 32'hffff_ffff);
        rd(12'h3f0, 32'h0);
        rd(`PIE_OFS_ENABLE, 32'h0000_0002);
    endtask : t_unmapped

    // Each source alone raises the request two cycles after its event
    task automatic t_source(input int b);
        wr(`PIE_OFS_ENABLE, 32'h1 << b);
        pulse(8'h1 << b);
        #1;
        chk({31'h0, irqRequest}, 32'h0, "request too early");
        @(posedge clk_sys);
        #1;
        chk({31'h0, irqRequest}, 32'h1, "request missing");
        wr(`PIE_OFS_EVENTS, 32'h1 << b);
        @(posedge clk_sys);
        #1;
        chk({31'h0, irqRequest}, 32'h0, "request stuck");
    endtask : t_source

    // A masked event stays silent until its enable is set
    task automatic t_masked();
        wr(`PIE_OFS_ENABLE, 32'h0000_00be);
        pulse(8'h40);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({31'h0, irqRequest}, 32'h0, "masked request");
        wr(`PIE_OFS_SET, 32'h0000_0040);
        @(posedge clk_sys);
        #1;
        chk({31'h0, irqRequest}, 32'h1, "unmasked request");
        wr(`PIE_OFS_CLEAR, 32'h0000_0040);
        @(posedge clk_sys);
        #1;
        chk({31'h0, irqRequest}, 32'h0, "remasked request");
        wr(`PIE_OFS_EVENTS, 32'h0000_0040);
    endtask : t_masked

    // ------------------------------------------------------------
    // Verdict and main sequence
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    // Watchdog well beyond the expected run of under two hundred cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        end_sim();
    end

    // Reset, then scenarios in turn
    initial begin
        fails = 0;
        n_compared = 0;
        rst_n = 1'h0;
        regAddr = 12'h0;
        regWrData = 32'h0;
        regWrite = 1'h0;
        regRead = 1'h0;
        ev = 8'h00;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'h1;
        rd(`PIE_OFS_ENABLE, 32'h0);
        rd(`PIE_OFS_SET, 32'h0);
        t_enable();
        t_set();
        t_clear();
        t_unmapped();
        for (int b = 1; b <= 7; b++) begin
            t_source(b);
        end
        t_masked();
        end_sim();
    end
endmodule : testbench
